// [design/vte_pkg.sv]
package vte_pkg;
	// port count and index widths
	localparam int NPORTS = 8;
	localparam int PW = 3;
	localparam int NVLAN = 255;
	localparam int IDXW = 8;
	localparam int VIDW = 12;

	// vlan identifier values
	localparam logic [11:0] VID_NULL = 12'h000;
	localparam logic [11:0] VID_DEFAULT = 12'h001;
	localparam logic [11:0] VID_MAX = 12'hffe;
	localparam logic [11:0] VID_RSVD = 12'hfff;

	// tag protocol identifier octets
	localparam logic [7:0] TPID_HI = 8'h81;
	localparam logic [7:0] TPID_LO = 8'h00;

	// header octet positions and lengths
	localparam logic [4:0] MAC_LEN = 5'h0c;
	localparam logic [3:0] POS_TYPE_HI = 4'hc;
	localparam logic [3:0] POS_TYPE_LO = 4'hd;
	localparam logic [3:0] POS_TCI_HI = 4'he;
	localparam logic [3:0] POS_TCI_LO = 4'hf;
	localparam logic [4:0] POS_TAG_END = 5'h10;
	localparam logic [4:0] HDR_MAX = 5'h10;
	localparam logic [4:0] HDR_MIN = 5'h0e;
	localparam logic [4:0] TAG_LEN = 5'h04;
	localparam logic [1:0] FCS_LAST = 2'h3;

	// register byte addresses
	localparam logic [7:0] A_MGMT = 8'h00;
	localparam logic [7:0] A_TIDX = 8'h04;
	localparam logic [7:0] A_TDATA = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0c;
	localparam logic [7:0] A_PORT_BASE = 8'h10;
	localparam logic [7:0] A_PORT_END = 8'h30;

	// field positions
	localparam int F_VALID = 12;
	localparam int F_MEMB = 16;
	localparam int F_TAG = 12;
	localparam int F_DROPS = 16;

	// crc constants, reflected ethernet polynomial
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;

	typedef enum logic [2:0] {
		S_HDR = 3'b000,
		S_DECIDE = 3'b001,
		S_EMIT = 3'b010,
		S_BODY = 3'b011,
		S_FCS = 3'b100,
		S_DROP = 3'b101
	} vte_state_t;
endpackage : vte_pkg

// [design/vte_crc.sv]
`timescale 1ns/1ps
module vte_crc (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic en,
	input wire logic [7:0] data,
	output logic [31:0] fcs
);
	logic [31:0] crc_reg;
	logic [31:0] crc_next;

	// bytewise update, lsb first as on the wire
	always_comb begin
		crc_next = crc_reg;
		for (int b = 0; b < 8; b++) begin
			if (crc_next[0] ^ data[b])
				crc_next = (crc_next >> 1) ^ vte_pkg::CRC_POLY;
			else
				crc_next = crc_next >> 1;
		end
	end

	// clear wins so a new frame never inherits a stale remainder
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			crc_reg <= vte_pkg::CRC_INIT;
		else if (clear)
			crc_reg <= vte_pkg::CRC_INIT;
		else if (en)
			crc_reg <= crc_next;
	end

	assign fcs = ~crc_reg;
endmodule : vte_crc

// [design/vte_table.sv]
`timescale 1ns/1ps
module vte_table (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_idx,
	input wire logic [11:0] wr_vid,
	input wire logic wr_valid,
	input wire logic [7:0] wr_member,
	input wire logic [7:0] rd_idx,
	output logic [11:0] rd_vid,
	output logic rd_valid,
	output logic [7:0] rd_member,
	input wire logic [11:0] look_vid,
	output logic [7:0] look_member
);
	logic [11:0] vid_q [vte_pkg::NVLAN];
	logic val_q [vte_pkg::NVLAN];
	logic [7:0] mem_q [vte_pkg::NVLAN];
	logic [7:0] hit_mem [vte_pkg::NVLAN];
	logic prune;

	// a new vlan takes its ports out of the default entry
	assign prune = wr_en && wr_valid && (wr_idx != 8'h00) &&
		(wr_vid != vte_pkg::VID_DEFAULT);

	genvar i;
	generate
		for (i = 0; i < vte_pkg::NVLAN; i++) begin : g_ent
			// entry 0 comes up as vlan 1 holding every port
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					vid_q[i] <= (i == 0) ? vte_pkg::VID_DEFAULT : 12'h000;
					val_q[i] <= (i == 0);
					mem_q[i] <= (i == 0) ? 8'hff : 8'h00;
				end else if (wr_en && wr_idx == 8'(i)) begin
					vid_q[i] <= wr_vid;
					val_q[i] <= wr_valid;
					mem_q[i] <= wr_member;
				end else if (i == 0 && prune) begin
					mem_q[i] <= mem_q[i] & ~wr_member;
				end
			end
			assign hit_mem[i] = (val_q[i] && vid_q[i] == look_vid) ?
				mem_q[i] : 8'h00;
		end
	endgenerate

	// duplicates just merge; no hit leaves an empty port set
	always_comb begin
		look_member = 8'h00;
		for (int k = 0; k < vte_pkg::NVLAN; k++)
			look_member = look_member | hit_mem[k];
	end

	// out-of-range index reads as zero
	always_comb begin
		if (rd_idx < 8'(vte_pkg::NVLAN)) begin
			rd_vid = vid_q[rd_idx];
			rd_valid = val_q[rd_idx];
			rd_member = mem_q[rd_idx];
		end else begin
			rd_vid = 12'h000;
			rd_valid = 1'b0;
			rd_member = 8'h00;
		end
	end
endmodule : vte_table

// [design/vte_classify_edit.sv]
`timescale 1ns/1ps
// What this block does
// - tag goes right after source address
// - type 0x8100 after source means tagged
// - tag control is priority, cfi, 12-bit id
// - priority kept apart from vlan id
// - insertion adds exactly four octets, rest intact
// - fresh fcs over every edited frame
// - ids 1 to 4094 usable
// - untagged frames take ingress default vlan
// - tagged frames with a nonzero id use their own id
// - drop when egress not member of vlan
// - one default vlan per port, many memberships
// - membership table holds 255 vlans
// - flooded frames stay inside their vlan
// - reset puts all ports untagged in vlan 1
// - joining new vlan leaves default vlan
// - egress tag mode per port
// - management vlan id writable and readable
// - default vlan limited to 1..4094
// - add, strip or pass tag per egress mode
module vte_classify_edit (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_sop,
	input wire logic in_eop,
	output logic in_ready,
	input wire logic [2:0] ingress_port,
	input wire logic [2:0] egress_port,
	output logic out_valid,
	output logic [7:0] out_data,
	output logic out_sop,
	output logic out_eop,
	output logic [11:0] frame_vid,
	output logic [2:0] frame_prio,
	output logic frame_drop
);
	vte_pkg::vte_state_t state_reg;
	vte_pkg::vte_state_t state_next;
	logic in_ready_reg;
	logic [7:0] hbuf [16];
	logic [4:0] hdr_cnt_reg;
	logic [4:0] hdr_len_reg;
	logic hdr_eop_reg;
	logic [3:0] hw_idx;
	logic [2:0] ig_reg;
	logic [2:0] eg_reg;
	logic acc;
	logic [11:0] port_default_vlan_reg [vte_pkg::NPORTS];
	logic tag_reg [vte_pkg::NPORTS];
	logic [11:0] mgmt_reg;
	logic [7:0] tidx_reg;
	logic [15:0] fwd_reg;
	logic [15:0] drop_reg;
	logic [31:0] rdata_reg;
	logic rx_tagged;
	logic [11:0] tag_vid;
	logic [11:0] cls_vid;
	logic bad;
	logic pass;
	logic do_ins;
	logic do_strip;
	logic [7:0] look_member;
	logic [11:0] rd_vid;
	logic rd_valid;
	logic [7:0] rd_member;
	logic tbl_wr;
	logic [7:0] port_off;
	logic port_hit;
	logic ins_reg;
	logic [4:0] emit_len_reg;
	logic [4:0] emit_idx_reg;
	logic [1:0] fcs_idx_reg;
	logic [11:0] vid_reg;
	logic [2:0] prio_reg;
	logic drop_pulse_reg;
	logic [7:0] emit_byte;
	logic ov_next;
	logic [7:0] od_next;
	logic osop_next;
	logic oeop_next;
	logic crc_en;
	logic [31:0] fcs;
	logic out_valid_reg;
	logic [7:0] out_data_reg;
	logic out_sop_reg;
	logic out_eop_reg;

	assign acc = in_valid && in_ready_reg;
	assign hw_idx = in_sop ? 4'h0 : hdr_cnt_reg[3:0];

	// header parse on the collected octets
	assign rx_tagged = (hdr_len_reg >= vte_pkg::HDR_MAX) &&
		(hbuf[vte_pkg::POS_TYPE_HI] == vte_pkg::TPID_HI) &&
		(hbuf[vte_pkg::POS_TYPE_LO] == vte_pkg::TPID_LO);
	assign tag_vid = {hbuf[vte_pkg::POS_TCI_HI][3:0],
		hbuf[vte_pkg::POS_TCI_LO]};

	// own id wins over port default; id 0 is a priority tag only
	assign cls_vid = (rx_tagged && tag_vid != vte_pkg::VID_NULL) ?
		tag_vid : port_default_vlan_reg[ig_reg];
	// runts and the reserved id never forward
	assign bad = (hdr_len_reg < vte_pkg::HDR_MIN) ||
		(rx_tagged && tag_vid == vte_pkg::VID_RSVD);
	// same check for known and flooded traffic
	assign pass = !bad && look_member[eg_reg];
	assign do_ins = !rx_tagged && tag_reg[eg_reg];
	assign do_strip = rx_tagged && !tag_reg[eg_reg];

	vte_table u_table (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.wr_en(tbl_wr),
		.wr_idx(tidx_reg),
		.wr_vid(reg_wdata[11:0]),
		.wr_valid(reg_wdata[vte_pkg::F_VALID]),
		.wr_member(reg_wdata[vte_pkg::F_MEMB +: 8]),
		.rd_idx(tidx_reg),
		.rd_vid(rd_vid),
		.rd_valid(rd_valid),
		.rd_member(rd_member),
		.look_vid(cls_vid),
		.look_member(look_member)
	);

	// frame sequencer, one frame fully out before the next
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			vte_pkg::S_HDR: begin
				if (acc && (in_eop || hw_idx == 4'hf))
					state_next = vte_pkg::S_DECIDE;
			end
			vte_pkg::S_DECIDE: begin
				if (pass)
					state_next = vte_pkg::S_EMIT;
				else if (hdr_eop_reg)
					state_next = vte_pkg::S_HDR;
				else
					state_next = vte_pkg::S_DROP;
			end
			vte_pkg::S_EMIT: begin
				if (emit_idx_reg == emit_len_reg - 5'h01)
					state_next = hdr_eop_reg ? vte_pkg::S_FCS :
						vte_pkg::S_BODY;
			end
			vte_pkg::S_BODY: begin
				if (acc && in_eop)
					state_next = vte_pkg::S_FCS;
			end
			vte_pkg::S_FCS: begin
				if (fcs_idx_reg == vte_pkg::FCS_LAST)
					state_next = vte_pkg::S_HDR;
			end
			vte_pkg::S_DROP: begin
				if (acc && in_eop)
					state_next = vte_pkg::S_HDR;
			end
			default: state_next = vte_pkg::S_HDR;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n)
			state_reg <= vte_pkg::S_HDR;
		else
			state_reg <= state_next;
	end

	// input stalls while the header is replayed or the fcs goes out
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			in_ready_reg <= 1'b0;
		else
			in_ready_reg <= (state_next == vte_pkg::S_HDR) ||
				(state_next == vte_pkg::S_BODY) ||
				(state_next == vte_pkg::S_DROP);
	end

	// header octet store
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_hbuf
			always_ff @(posedge core_clk) begin
				if (!reset_n)
					hbuf[g] <= 8'h00;
				else if (acc && state_reg == vte_pkg::S_HDR &&
					hw_idx == 4'(g))
					hbuf[g] <= in_data;
			end
		end
	endgenerate

	// header count, length and port capture
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			hdr_cnt_reg <= 5'h00;
			hdr_len_reg <= 5'h00;
			hdr_eop_reg <= 1'b0;
			ig_reg <= 3'h0;
			eg_reg <= 3'h0;
		end else if (acc && state_reg == vte_pkg::S_HDR) begin
			hdr_cnt_reg <= {1'b0, hw_idx} + 5'h01;
			hdr_len_reg <= {1'b0, hw_idx} + 5'h01;
			hdr_eop_reg <= in_eop;
			if (hw_idx == 4'h0) begin
				ig_reg <= ingress_port;
				eg_reg <= egress_port;
			end
		end else if (state_reg == vte_pkg::S_DECIDE) begin
			hdr_cnt_reg <= 5'h00;
		end
	end

	// per-frame decision; edited length is known before output starts
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ins_reg <= 1'b0;
			emit_len_reg <= 5'h00;
			vid_reg <= vte_pkg::VID_DEFAULT;
			prio_reg <= 3'h0;
			drop_pulse_reg <= 1'b0;
		end else begin
			drop_pulse_reg <= (state_reg == vte_pkg::S_DECIDE) && !pass;
			if (state_reg == vte_pkg::S_DECIDE) begin
				ins_reg <= do_ins;
				vid_reg <= cls_vid;
				// priority stays apart from the id
				prio_reg <= rx_tagged ?
					hbuf[vte_pkg::POS_TCI_HI][7:5] : 3'h0;
				if (do_ins)
					emit_len_reg <= hdr_len_reg + vte_pkg::TAG_LEN;
				else if (do_strip)
					emit_len_reg <= vte_pkg::MAC_LEN;
				else
					emit_len_reg <= hdr_len_reg;
			end
		end
	end

	// replay counters
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			emit_idx_reg <= 5'h00;
			fcs_idx_reg <= 2'h0;
		end else if (state_reg == vte_pkg::S_DECIDE) begin
			emit_idx_reg <= 5'h00;
			fcs_idx_reg <= 2'h0;
		end else if (state_reg == vte_pkg::S_EMIT) begin
			emit_idx_reg <= emit_idx_reg + 5'h01;
		end else if (state_reg == vte_pkg::S_FCS) begin
			fcs_idx_reg <= fcs_idx_reg + 2'h1;
		end
	end

	// replayed header: tag lands after the source address
	always_comb begin
		emit_byte = hbuf[emit_idx_reg[3:0]];
		if (ins_reg && emit_idx_reg >= vte_pkg::MAC_LEN) begin
			if (emit_idx_reg == vte_pkg::MAC_LEN)
				emit_byte = vte_pkg::TPID_HI;
			else if (emit_idx_reg == vte_pkg::MAC_LEN + 5'h01)
				emit_byte = vte_pkg::TPID_LO;
			else if (emit_idx_reg == vte_pkg::MAC_LEN + 5'h02)
				emit_byte = {3'h0, 1'b0, vid_reg[11:8]};
			else if (emit_idx_reg == vte_pkg::MAC_LEN + 5'h03)
				emit_byte = vid_reg[7:0];
			else // original octets shifted by four
				emit_byte = hbuf[4'(emit_idx_reg - vte_pkg::TAG_LEN)];
		end
	end

	// output byte selection; fcs goes out lsb first
	always_comb begin
		ov_next = 1'b0;
		od_next = 8'h00;
		osop_next = 1'b0;
		oeop_next = 1'b0;
		crc_en = 1'b0;
		case (state_reg)
			vte_pkg::S_EMIT: begin
				ov_next = 1'b1;
				od_next = emit_byte;
				osop_next = (emit_idx_reg == 5'h00);
				crc_en = 1'b1;
			end
			vte_pkg::S_BODY: begin
				ov_next = acc;
				od_next = in_data;
				crc_en = acc;
			end
			vte_pkg::S_FCS: begin
				ov_next = 1'b1;
				od_next = 8'(fcs >> {fcs_idx_reg, 3'h0});
				oeop_next = (fcs_idx_reg == vte_pkg::FCS_LAST);
			end
			default: ov_next = 1'b0;
		endcase
	end

	// remainder restarts at every decision, so every forwarded frame gets new fcs
	vte_crc u_crc (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(state_reg == vte_pkg::S_DECIDE),
		.en(crc_en),
		.data(od_next),
		.fcs(fcs)
	);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			out_valid_reg <= 1'b0;
			out_data_reg <= 8'h00;
			out_sop_reg <= 1'b0;
			out_eop_reg <= 1'b0;
		end else begin
			out_valid_reg <= ov_next;
			out_data_reg <= od_next;
			out_sop_reg <= osop_next;
			out_eop_reg <= oeop_next;
		end
	end

	// register decode
	assign port_hit = (reg_addr >= vte_pkg::A_PORT_BASE) &&
		(reg_addr < vte_pkg::A_PORT_END);
	assign port_off = reg_addr - vte_pkg::A_PORT_BASE;
	// reserved ids are never stored
	assign tbl_wr = reg_write && (reg_addr == vte_pkg::A_TDATA) &&
		(reg_wdata[11:0] != vte_pkg::VID_NULL) &&
		(reg_wdata[11:0] != vte_pkg::VID_RSVD);

	// one default vlan and mode per port, reset to vlan 1 untagged
	generate
		for (g = 0; g < vte_pkg::NPORTS; g++) begin : g_port
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					port_default_vlan_reg[g] <= vte_pkg::VID_DEFAULT;
					tag_reg[g] <= 1'b0;
				end else if (reg_write && port_hit &&
					port_off[4:2] == 3'(g)) begin
					tag_reg[g] <= reg_wdata[vte_pkg::F_TAG];
					// out-of-range default is ignored, old value kept
					if (reg_wdata[11:0] != vte_pkg::VID_NULL &&
						reg_wdata[11:0] <= vte_pkg::VID_MAX)
						port_default_vlan_reg[g] <= reg_wdata[11:0];
				end
			end
		end
	endgenerate

	// management id and table index
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			mgmt_reg <= vte_pkg::VID_DEFAULT;
			tidx_reg <= 8'h00;
		end else if (reg_write) begin
			if (reg_addr == vte_pkg::A_MGMT)
				mgmt_reg <= reg_wdata[11:0];
			if (reg_addr == vte_pkg::A_TIDX)
				tidx_reg <= reg_wdata[7:0];
		end
	end

	// frame counters wrap silently; software takes differences
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			fwd_reg <= 16'h0000;
			drop_reg <= 16'h0000;
		end else if (state_reg == vte_pkg::S_DECIDE) begin
			if (pass)
				fwd_reg <= fwd_reg + 16'h0001;
			else
				drop_reg <= drop_reg + 16'h0001;
		end
	end

	// read data stands for one cycle; unmapped reads zero
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rdata_reg <= 32'h00000000;
		end else if (!reg_read) begin
			rdata_reg <= 32'h00000000;
		end else if (reg_addr == vte_pkg::A_MGMT) begin
			rdata_reg <= {20'h00000, mgmt_reg};
		end else if (reg_addr == vte_pkg::A_TIDX) begin
			rdata_reg <= {24'h000000, tidx_reg};
		end else if (reg_addr == vte_pkg::A_TDATA) begin
			rdata_reg <= {8'h00, rd_member, 3'h0, rd_valid, rd_vid};
		end else if (reg_addr == vte_pkg::A_STAT) begin
			rdata_reg <= {drop_reg, fwd_reg};
		end else if (port_hit) begin
			rdata_reg <= {19'h00000, tag_reg[port_off[4:2]],
				port_default_vlan_reg[port_off[4:2]]};
		end else begin
			rdata_reg <= 32'h00000000;
		end
	end

	assign reg_rdata = rdata_reg;
	assign in_ready = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_data = out_data_reg;
	assign out_sop = out_sop_reg;
	assign out_eop = out_eop_reg;
	assign frame_vid = vid_reg;
	assign frame_prio = prio_reg;
	assign frame_drop = drop_pulse_reg;
endmodule : vte_classify_edit

// [tb/vte_chk.sv]
`timescale 1ns/1ps
// port-level checks on the classifier, register slot and frame framing
module vte_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_sop,
	input wire logic out_eop,
	input wire logic [11:0] frame_vid,
	input wire logic frame_drop
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	AST_RDATA_IDLE: assert property (
		!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	AST_DROP_PULSE: assert property (
		frame_drop |=> !frame_drop)
		else $error("drop pulse longer than one cycle");
	AST_DROP_NO_OUT: assert property (
		frame_drop |-> !out_valid)
		else $error("output while dropping");
	AST_VID_NZ: assert property (
		frame_vid != 12'h000)
		else $error("classified vlan is zero");
	AST_SOP_VALID: assert property (
		out_sop |-> out_valid)
		else $error("start without valid");
	AST_EOP_VALID: assert property (
		out_eop |-> out_valid)
		else $error("end without valid");
	// header replay is gapless, so a frame start runs at least eight bytes
	AST_HDR_RUN: assert property (
		out_sop |-> (out_valid && !out_eop)[*8])
		else $error("header replay broken");
	// next frame needs a full header before any output
	AST_EOP_GAP: assert property (
		out_eop |=> (!out_valid)[*8])
		else $error("output too soon after frame end");
	AST_SOP_NOT_READY: assert property (
		out_sop |-> !in_ready)
		else $error("input taken during header replay");
endmodule : vte_chk

bind vte_classify_edit vte_chk vte_chk_inst (
	.core_clk(core_clk),
	.reset_n(reset_n),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.in_ready(in_ready),
	.out_valid(out_valid),
	.out_sop(out_sop),
	.out_eop(out_eop),
	.frame_vid(frame_vid),
	.frame_drop(frame_drop)
);

// [tb/vte_port_model.sv]
`timescale 1ns/1ps
// far-side station: sends one frame from tx_q, collects output in rx_q
module vte_port_model (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	input wire logic out_sop,
	input wire logic out_eop,
	input wire logic frame_drop,
	output logic in_valid,
	output logic [7:0] in_data,
	output logic in_sop,
	output logic in_eop
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	int idx = 0;
	int n;
	logic gap = 1'b0;
	logic done = 1'b0;
	logic dropped = 1'b0;
	// output positions of the frame flags, -1 until seen
	int sop_at = -1;
	int eop_at = -1;

	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		in_sop = 1'b0;
		in_eop = 1'b0;
	end

	// pointer moves only on an accepted byte; slow mode idles every other cycle
	always @(posedge core_clk) begin
		n = idx + int'(in_valid && in_ready);
		idx = n;
		gap <= slow & ~gap;
		if (n < tx_q.size() && !(slow && gap)) begin
			in_valid <= 1'b1;
			in_data <= tx_q[n];
			in_sop <= n == 0;
			in_eop <= n == tx_q.size() - 1;
		end else begin
			// idle line shows a changing pattern, the last byte and its inverse in turn
			in_valid <= 1'b0;
			in_data <= ~in_data;
			in_sop <= 1'b0;
			in_eop <= 1'b0;
		end
		if (out_sop)
			sop_at = rx_q.size();
		if (out_eop)
			eop_at = rx_q.size();
		if (out_valid)
			rx_q.push_back(out_data);
		if (out_eop || frame_drop)
			done = 1'b1;
		if (frame_drop)
			dropped = 1'b1;
	end
endmodule : vte_port_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	typedef logic [7:0] vte_bytes_t[$];
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic in_valid, in_sop, in_eop, in_ready;
	logic out_valid, out_sop, out_eop, frame_drop;
	logic [7:0] in_data, out_data;
	logic [2:0] ingress_port = 3'h0;
	logic [2:0] egress_port = 3'h0;
	logic [11:0] frame_vid;
	logic [2:0] frame_prio;
	logic slow = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	vte_bytes_t u, t1, t10, e, none;

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	vte_classify_edit vte_classify_edit_inst (
		.core_clk(core_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .in_valid(in_valid),
		.in_data(in_data), .in_sop(in_sop), .in_eop(in_eop),
		.in_ready(in_ready), .ingress_port(ingress_port),
		.egress_port(egress_port), .out_valid(out_valid),
		.out_data(out_data), .out_sop(out_sop), .out_eop(out_eop),
		.frame_vid(frame_vid), .frame_prio(frame_prio),
		.frame_drop(frame_drop)
	);

	vte_port_model vte_port_model_inst (
		.core_clk(core_clk), .slow(slow), .in_ready(in_ready),
		.out_valid(out_valid), .out_data(out_data),
		.out_sop(out_sop), .out_eop(out_eop), .frame_drop(frame_drop),
		.in_valid(in_valid), .in_data(in_data),
		.in_sop(in_sop), .in_eop(in_eop)
	);

	task summarize;
		if (n_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	task chk(input string name, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe edge
	task rd(input logic [7:0] a, input logic [31:0] x, input string s);
		@(posedge core_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 chk(s, x, reg_rdata);
	endtask : rd

	// broadcast destination keeps flooded traffic inside its vlan
	function automatic vte_bytes_t mk(input logic [7:0] a, b, c, d);
		vte_bytes_t q;
		q = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
			8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, a, b, c, d};
		for (int i = 0; i < 6; i++)
			q.push_back(8'h30 + 8'(i));
		return q;
	endfunction : mk

	// own crc, appended low byte first
	function automatic vte_bytes_t fcs(input vte_bytes_t q);
		logic [31:0] c;
		c = vte_pkg::CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {24'h0, q[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ vte_pkg::CRC_POLY : c >> 1;
		end
		c = ~c;
		for (int k = 0; k < 4; k++)
			q.push_back(c[8*k +: 8]);
		return q;
	endfunction : fcs

	// empty expectation means the frame must be dropped
	task frame(input vte_bytes_t f, input logic [2:0] ip, ep,
		input vte_bytes_t x, input logic [11:0] vid);
		vte_bytes_t g;
		@(posedge core_clk);
		ingress_port <= ip;
		egress_port <= ep;
		@(negedge core_clk);
		vte_port_model_inst.tx_q = f;
		vte_port_model_inst.rx_q = {};
		vte_port_model_inst.idx = 0;
		vte_port_model_inst.done = 1'b0;
		vte_port_model_inst.dropped = 1'b0;
		vte_port_model_inst.sop_at = -1;
		vte_port_model_inst.eop_at = -1;
		for (int k = 0; k < 400; k++) begin
			if (vte_port_model_inst.done &&
				vte_port_model_inst.idx >= f.size())
				break;
			@(posedge core_clk);
		end
		repeat (2) @(posedge core_clk);
		g = x;
		if (x.size() > 0)
			g = fcs(x);
		// a frame that never finished is a failure, not a skip
		chk("done", 32'h1, 32'(vte_port_model_inst.done));
		chk("consumed", 32'(f.size()),
			32'(vte_port_model_inst.idx));
		chk("drop", 32'(x.size() == 0),
			32'(vte_port_model_inst.dropped));
		chk("length", 32'(g.size()),
			32'(vte_port_model_inst.rx_q.size()));
		if (g.size() == vte_port_model_inst.rx_q.size())
			foreach (g[i])
				chk("byte", 32'(g[i]),
					32'(vte_port_model_inst.rx_q[i]));
		if (x.size() > 0) begin
			chk("vid", 32'(vid), 32'(frame_vid));
			chk("sop", 32'h0, 32'(vte_port_model_inst.sop_at));
			chk("eop", 32'(g.size() - 1),
				32'(vte_port_model_inst.eop_at));
		end
	endtask : frame

	// hang guard well above the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			summarize();
		end
	end

	initial begin
		u = mk(8'h08, 8'h00, 8'h45, 8'h00);
		t1 = mk(8'h81, 8'h00, 8'ha0, 8'h01);
		t10 = mk(8'h81, 8'h00, 8'h00, 8'h0a);
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(vte_pkg::A_MGMT, 32'h1, "mgmt");
		rd(vte_pkg::A_PORT_BASE, 32'h1, "port 0");
		rd(8'h2c, 32'h1, "port 7");
		rd(vte_pkg::A_TDATA, 32'h00ff1001, "entry 0");
		rd(8'h40, 32'h0, "unmapped");
		chk("reset vid", 32'h1, 32'(frame_vid));
		wr(vte_pkg::A_MGMT, 32'h0a5);
		rd(vte_pkg::A_MGMT, 32'h0a5, "mgmt");
		wr(8'h14, 32'h0);
		wr(8'h14, 32'hfff);
		rd(8'h14, 32'h1, "port 1");
		frame(u, 3'h0, 3'h1, u, 12'h001);
		wr(8'h18, 32'h1001);
		e = {u[0:11], 8'h81, 8'h00, 8'h00, 8'h01, u[12:$]};
		frame(u, 3'h0, 3'h2, e, 12'h001);
		frame(t1, 3'h3, 3'h2, t1, 12'h001);
		chk("prio", 32'h5, 32'(frame_prio));
		e = {t1[0:11], t1[16:$]};
		frame(t1, 3'h3, 3'h1, e, 12'h001);
		// vlan 10 on port 2 only
		wr(vte_pkg::A_TIDX, 32'h1);
		wr(vte_pkg::A_TDATA, 32'h0004100a);
		rd(vte_pkg::A_TDATA, 32'h0004100a, "entry 1");
		wr(vte_pkg::A_TIDX, 32'h0);
		rd(vte_pkg::A_TDATA, 32'h00fb1001, "entry 0");
		frame(t1, 3'h3, 3'h2, none, 12'h001);
		slow <= 1'b1;
		frame(t10, 3'h5, 3'h2, t10, 12'h00a);
		slow <= 1'b0;
		frame(t10, 3'h5, 3'h1, none, 12'h00a);
		frame(u, 3'h0, 3'h2, none, 12'h001);
		e = mk(8'h81, 8'h01, 8'h00, 8'h0a);
		frame(e, 3'h0, 3'h1, e, 12'h001);
		wr(8'h1c, 32'h100a);
		e = {u[0:11], 8'h81, 8'h00, 8'h00, 8'h0a, u[12:$]};
		frame(u, 3'h3, 3'h2, e, 12'h00a);
		// reserved id must never reach the table
		wr(vte_pkg::A_TIDX, 32'h2);
		wr(vte_pkg::A_TDATA, 32'h00ff1fff);
		rd(vte_pkg::A_TDATA, 32'h0, "entry 2");
		rd(vte_pkg::A_STAT, 32'h00030007, "status");
		summarize();
	end
endmodule : testbench
